// [bench/far_station.sv]
// Far station model: counts pause frames and jam bursts that reach the link.
// Assumes pause and pressure outputs of the block are synchronous to sys_clk.
`timescale 1ns/100ps

module far_station
(
    input  wire logic                               sys_clk,
    input  wire logic                               pauseSend,
    input  wire logic [flow_ctrl_pkg::PAUSE_W-1:0]  pauseTime,
    input  wire logic                               backPressure,
    output logic [31:0]                             pauses,
    output logic [flow_ctrl_pkg::PAUSE_W-1:0]       lastPause,
    output logic [31:0]                             jams,
    output logic [31:0]                             lastJam
);
    import flow_ctrl_pkg::*;

    logic [31:0] run;

    initial
    begin
        pauses = '0;
        lastPause = '0;
        jams = '0;
        lastJam = '0;
        run = '0;
    end

    // A jam burst is recorded with its length when pressure falls
    always @(posedge sys_clk)
    begin
        if (pauseSend === 1'b1)
        begin
            pauses <= pauses + 1;
            lastPause <= pauseTime;
        end
        if (backPressure === 1'b1)
            run <= run + 1;
        else if (run != 0)
        begin
            jams <= jams + 1;
            lastJam <= run;
            run <= '0;
        end
    end
endmodule : far_station

// [bench/tb_top.sv]
// Testbench for auto_flow_control: APB register tasks and link scenarios.
// Assumes a far_station model on the pause and pressure outputs.
`timescale 1ns/100ps

module tb_top;
    import flow_ctrl_pkg::*;

    logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, macLoadData = '0, prdata, windowData;
    logic pready, pslverr, pauseSend, backPressure, macLoad = 1'b0;
    logic txEnable = 1'b1, fullDuplex = 1'b1, speed100 = 1'b1, rxPreamble = 1'b0;
    logic rxAddrValid = 1'b0, rxMulticast = 1'b0, rxBroadcast = 1'b0, rxOwnAddr = 1'b0;
    logic [13:0] rxFifoBytes = '0;
    logic [PAUSE_W-1:0] pauseTimeValue = 16'h1234, pauseTime, lastPause;
    logic [31:0] pauses, jams, lastJam;
    int fail_count = 0, cmp_count = 0;

    // Period codes give 1..16 cycles at 100 Mb/s, two more at 10 Mb/s
    auto_flow_control #(.FIFO_BITS(14), .PRESSURE_10M_EXTRA_NS(10),
        .PRESSURE_100M_NS('{5, 10, 15, 20, 25, 30, 35, 40, 45, 50, 55, 60, 65, 70, 75, 80}))
    dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .macLoad(macLoad), .macLoadData(macLoadData), .windowData(windowData),
        .txEnable(txEnable), .fullDuplex(fullDuplex), .speed100(speed100),
        .rxFifoBytes(rxFifoBytes), .rxPreamble(rxPreamble), .rxAddrValid(rxAddrValid),
        .rxMulticast(rxMulticast), .rxBroadcast(rxBroadcast), .rxOwnAddr(rxOwnAddr),
        .pauseTimeValue(pauseTimeValue), .pauseSend(pauseSend), .pauseTime(pauseTime),
        .backPressure(backPressure));

    far_station station (.sys_clk(sys_clk), .pauseSend(pauseSend), .pauseTime(pauseTime),
        .backPressure(backPressure), .pauses(pauses), .lastPause(lastPause), .jams(jams),
        .lastJam(lastJam));

    always #2.5 sys_clk = ~sys_clk;

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, '0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, expErr});
    endtask : rd

    function automatic logic [31:0] cfg(input logic [3:0] dur, input logic [3:0] sel);
        return {8'h00, 8'h02, 8'h01, dur, sel};
    endfunction : cfg

    // Frame event: a preamble, or a decoded address with match flags {mult, brd, own}
    task automatic hit(input logic pre, input logic [2:0] mbo);
        rxPreamble <= pre;
        rxAddrValid <= ~pre;
        {rxMulticast, rxBroadcast, rxOwnAddr} <= mbo;
        @(posedge sys_clk);
        rxPreamble <= 1'b0;
        rxAddrValid <= 1'b0;
        repeat (24) @(posedge sys_clk);
    endtask : hit

    initial
    begin
        #(5 * 20000);
        fail_count++;
        results();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd(WINDOW_DATA_OFS, 32'h0000_0000, 1'b0);
        rd(FLOW_CFG_OFS, 32'h0000_0000, 1'b0);
        wr(WINDOW_DATA_OFS, 32'hA5A5_0F0F);
        chk(windowData, 32'hA5A5_0F0F);
        rd(WINDOW_DATA_OFS, 32'hA5A5_0F0F, 1'b0);
        macLoad <= 1'b1;
        macLoadData <= 32'h1357_9BDF;
        @(posedge sys_clk);
        macLoad <= 1'b0;
        @(posedge sys_clk);
        chk(windowData, 32'h1357_9BDF);
        rd(WINDOW_DATA_OFS, 32'h1357_9BDF, 1'b0);
        rd(12'h0b0, 32'h0000_0000, 1'b1);
        wr(FLOW_CFG_OFS, 32'hFF02_0101);
        rd(FLOW_CFG_OFS, 32'h0002_0101, 1'b0);
        hit(1'b1, 3'b000);
        chk(pauses, 32'h0000_0000);
        rxFifoBytes <= 14'd127;
        hit(1'b1, 3'b000);
        chk(pauses, 32'h0000_0000);
        rxFifoBytes <= 14'd128;
        hit(1'b1, 3'b000);
        chk(pauses, 32'h0000_0001);
        chk({16'h0, lastPause}, 32'h0000_1234);
        hit(1'b1, 3'b000);
        chk(pauses, 32'h0000_0001);
        rxFifoBytes <= 14'd64;
        repeat (8) @(posedge sys_clk);
        chk(pauses, 32'h0000_0001);
        rxFifoBytes <= 14'd63;
        repeat (8) @(posedge sys_clk);
        chk(pauses, 32'h0000_0002);
        chk({16'h0, lastPause}, 32'h0000_0000);
        rxFifoBytes <= 14'd128;
        wr(FLOW_CFG_OFS, cfg(4'h0, 4'hE));
        hit(1'b0, 3'b111);
        hit(1'b1, 3'b000);
        chk(pauses, 32'h0000_0002);
        wr(FLOW_CFG_OFS, cfg(4'h0, 4'h1));
        txEnable <= 1'b0;
        hit(1'b1, 3'b000);
        chk(pauses, 32'h0000_0002);
        fullDuplex <= 1'b0;
        hit(1'b1, 3'b000);
        chk(jams, 32'h0000_0000);
        txEnable <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wr(FLOW_CFG_OFS, cfg(4'h0, 4'h8 >> i));
            hit(1'b0, ~(3'b100 >> i));
            hit(1'b0, 3'b100 >> i);
            chk(jams, 32'(i + 1));
            chk(lastJam, 32'h0000_0001);
        end
        wr(FLOW_CFG_OFS, cfg(4'hF, 4'h9));
        hit(1'b0, 3'b100);
        chk(jams, 32'h0000_0003);
        rxFifoBytes <= 14'd127;
        hit(1'b1, 3'b000);
        chk(jams, 32'h0000_0003);
        rxFifoBytes <= 14'd128;
        hit(1'b1, 3'b000);
        chk(lastJam, 32'h0000_0010);
        speed100 <= 1'b0;
        hit(1'b1, 3'b000);
        chk(lastJam, 32'h0000_0012);
        chk(jams, 32'h0000_0005);
        speed100 <= 1'b1;
        fullDuplex <= 1'b1;
        hit(1'b1, 3'b000);
        chk(jams, 32'h0000_0005);
        chk(pauses, 32'h0000_0003);
        results();
    end
endmodule : tb_top

// [hdl/auto_flow_control.sv]
// Automatic flow control configuration and MAC window data register.
// Assumes FIFO level, frame events and MAC controls come from logic on sys_clk.
//
// Overview of operation
// - Window data register, 32 bits, resets zero
// - No pause or pressure while transmitter disabled
// - Trigger at high threshold, 64-byte units
// - Full duplex: one pause per crossing
// - Half duplex: jam matching frames for period
// - Below low threshold: send zero-time pause
// - Zero pause only after high pause sent
// - Pressure period field, unused in full duplex
// - Period codes map 5 to 600 us at 100 Mb/s
// - Multicast select bit, half duplex only
// - Broadcast select bit, half duplex only
// - Own-address select bit, half duplex only
// - Any-frame bit; sole full-duplex enable
// - Any-frame reacts at next valid preamble
// - Any-frame overrides the other select bits
`timescale 1ns/100ps

module auto_flow_control
    import flow_ctrl_pkg::*;
#(
    parameter int unsigned FIFO_BITS             = flow_ctrl_pkg::FIFO_W,
    parameter flow_ctrl_pkg::dur_table_t PRESSURE_100M_NS = flow_ctrl_pkg::BP_TIME_100M_NS,
    parameter int unsigned PRESSURE_10M_EXTRA_NS = flow_ctrl_pkg::BP_EXTRA_10M_NS
)
(
    input  wire logic                                sys_clk,
    input  wire logic                                rst_b,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [flow_ctrl_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [flow_ctrl_pkg::DATA_W-1:0]    pwdata,
    output logic                                     pready,
    output logic [flow_ctrl_pkg::DATA_W-1:0]         prdata,
    output logic                                     pslverr,
    input  wire logic                                macLoad,
    input  wire logic [flow_ctrl_pkg::DATA_W-1:0]    macLoadData,
    output logic [flow_ctrl_pkg::DATA_W-1:0]         windowData,
    input  wire logic                                txEnable,
    input  wire logic                                fullDuplex,
    input  wire logic                                speed100,
    input  wire logic [FIFO_BITS-1:0]                rxFifoBytes,
    input  wire logic                                rxPreamble,
    input  wire logic                                rxAddrValid,
    input  wire logic                                rxMulticast,
    input  wire logic                                rxBroadcast,
    input  wire logic                                rxOwnAddr,
    input  wire logic [flow_ctrl_pkg::PAUSE_W-1:0]   pauseTimeValue,
    output logic                                     pauseSend,
    output logic [flow_ctrl_pkg::PAUSE_W-1:0]        pauseTime,
    output logic                                     backPressure
);
    import flow_ctrl_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]   windowData;
        logic [LEVEL_W-1:0]  highLevel;
        logic [LEVEL_W-1:0]  lowLevel;
        logic [PERIOD_W-1:0] period;
        logic [SELECT_W-1:0] select;
        logic                pauseSent;
        logic [COUNT_W-1:0]  pressureCount;
        logic                backPressure;
        logic                pauseSend;
        logic [PAUSE_W-1:0]  pauseTime;
        logic                pready;
        logic [DATA_W-1:0]   prdata;
        logic                pslverr;
    } state_t;

    state_t             q;
    state_t             d;
    logic [COUNT_W-1:0] cycles100 [DUR_CODES];
    logic [COUNT_W-1:0] cycles10  [DUR_CODES];
    logic [FIFO_BITS:0] fifoLevel;
    logic [FIFO_BITS:0] highBytes;
    logic [FIFO_BITS:0] lowBytes;
    logic               aboveHigh;
    logic               belowLow;
    logic               anySelect;
    logic               frameHit;
    logic [COUNT_W-1:0] pressureLoad;
    logic [DATA_W-1:0]  configWord;

    // Pressure period per code, both line rates
    for (genvar i = 0; i < DUR_CODES; i++)
    begin : g_period
        assign cycles100[i] = COUNT_W'(cycles_from_ns(PRESSURE_100M_NS[i]));
        assign cycles10[i]  = COUNT_W'(cycles_from_ns(PRESSURE_100M_NS[i]
                                                      + PRESSURE_10M_EXTRA_NS));
    end

    assign fifoLevel = (FIFO_BITS+1)'(rxFifoBytes);
    assign highBytes = (FIFO_BITS+1)'({q.highLevel, {UNIT_SHIFT{1'b0}}});
    assign lowBytes  = (FIFO_BITS+1)'({q.lowLevel, {UNIT_SHIFT{1'b0}}});
    assign aboveHigh = (fifoLevel >= highBytes);
    assign belowLow  = (fifoLevel < lowBytes);
    assign anySelect = q.select[ANY_BIT];

    // Any-frame fires on the preamble and masks the address-based selects
    assign frameHit = anySelect ? rxPreamble :
                      (rxAddrValid &&
                       ((q.select[MULT_BIT] && rxMulticast)  ||
                        (q.select[BRD_BIT]  && rxBroadcast)  ||
                        (q.select[OWN_BIT]  && rxOwnAddr)));

    assign pressureLoad = speed100 ? cycles100[q.period] : cycles10[q.period];

    assign configWord = (DATA_W'(q.highLevel) << HI_LSB) |
                        (DATA_W'(q.lowLevel)  << LO_LSB) |
                        (DATA_W'(q.period)    << DUR_LSB) |
                        DATA_W'(q.select);

    always_comb
    begin
        d           = q;
        d.pready    = 1'b0;
        d.pslverr   = 1'b0;
        d.pauseSend = 1'b0;

        // APB: answer one cycle into the access phase
        if (psel && penable && !q.pready)
        begin
            d.pready = 1'b1;
            case (paddr)
                WINDOW_DATA_OFS: d.prdata = q.windowData;
                FLOW_CFG_OFS:    d.prdata = configWord;
                default:
                begin
                    d.prdata  = READ_ZERO;
                    d.pslverr = 1'b1;
                end
            endcase
        end

        // Writes land at the edge where the master sees pready
        if (psel && penable && q.pready && pwrite)
        begin
            case (paddr)
                WINDOW_DATA_OFS: d.windowData = pwdata;
                FLOW_CFG_OFS:
                begin
                    d.highLevel = pwdata[HI_LSB +: LEVEL_W];
                    d.lowLevel  = pwdata[LO_LSB +: LEVEL_W];
                    d.period    = pwdata[DUR_LSB +: PERIOD_W];
                    d.select    = pwdata[ANY_BIT +: SELECT_W];
                end
                default: d.windowData = q.windowData;
            endcase
        end

        // Read result returned from the MAC side
        if (macLoad)
        begin
            d.windowData = macLoadData;
        end

        // Full duplex pause frames
        if (fullDuplex && txEnable)
        begin
            if (anySelect && aboveHigh && rxPreamble && !q.pauseSent)
            begin
                d.pauseSend = 1'b1;
                d.pauseTime = pauseTimeValue;
                d.pauseSent = 1'b1;
            end
            else if (q.pauseSent && belowLow)
            begin
                d.pauseSend = 1'b1;
                d.pauseTime = ZERO_PAUSE;
                d.pauseSent = 1'b0;
            end
        end

        // Half duplex back pressure
        if (fullDuplex || !txEnable)
        begin
            d.pressureCount = '0;
        end
        else if (aboveHigh && frameHit)
        begin
            d.pressureCount = pressureLoad;
        end
        else if (q.pressureCount != '0)
        begin
            d.pressureCount = q.pressureCount - COUNT_W'(1);
        end
        d.backPressure = (d.pressureCount != '0);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q            <= '0;
            q.windowData <= WINDOW_DATA_RST;
            q.highLevel  <= LEVEL_RST;
            q.lowLevel   <= LEVEL_RST;
            q.period     <= PERIOD_RST;
            q.select     <= SELECT_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign pready       = q.pready;
    assign prdata       = q.prdata;
    assign pslverr      = q.pslverr;
    assign windowData   = q.windowData;
    assign pauseSend    = q.pauseSend;
    assign pauseTime    = q.pauseTime;
    assign backPressure = q.backPressure;

    // Checks
    a_window_read_data: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (psel && penable && !q.pready && !pwrite && paddr == WINDOW_DATA_OFS)
        |=> (pready && prdata == $past(q.windowData)))
        else $error("window data read returned wrong value");

    a_pause_tx_off: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        pauseSend |-> $past(txEnable))
        else $error("pause frame sent with transmitter disabled");

    a_pressure_tx_off: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !txEnable |=> !backPressure)
        else $error("back pressure with transmitter disabled");

    a_high_pause_sent: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (fullDuplex && txEnable && anySelect && aboveHigh && rxPreamble && !q.pauseSent)
        |=> (pauseSend && pauseTime == $past(pauseTimeValue)))
        else $error("high threshold pause missing or wrong time");

    a_single_pause: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (q.pauseSent && aboveHigh) |=> !pauseSend)
        else $error("second pause frame for one crossing");

    a_zero_pause_sent: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (fullDuplex && txEnable && q.pauseSent && belowLow && !aboveHigh)
        |=> (pauseSend && pauseTime == ZERO_PAUSE))
        else $error("zero-time pause missing");

    a_zero_after_high: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (pauseSend && !$past(q.pauseSent)) |-> $past(aboveHigh))
        else $error("pause frame without prior high crossing");

    a_jam_on_match: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (!fullDuplex && txEnable && aboveHigh && frameHit)
        |=> (backPressure && q.pressureCount == $past(pressureLoad)))
        else $error("matching frame not jammed");

    a_full_duplex_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        fullDuplex |=> !backPressure)
        else $error("back pressure in full duplex");

    a_any_overrides: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (anySelect && !rxPreamble && q.pressureCount == '0 && !fullDuplex)
        |=> !backPressure)
        else $error("address select acted with any-frame set");

    a_window_write: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (pready && psel && penable && pwrite && paddr == WINDOW_DATA_OFS && !macLoad)
        |=> (windowData == $past(pwdata)))
        else $error("window data write did not land");

    a_mac_load: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        macLoad
        |=> (windowData == $past(macLoadData)))
        else $error("MAC read return not stored in window data");

    a_pready_pulse: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        pready
        |=> !pready)
        else $error("ready held longer than one cycle");

    a_cfg_top_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (pready && $past(paddr) == FLOW_CFG_OFS)
        |-> (prdata[DATA_W-1:HI_LSB+LEVEL_W] == '0))
        else $error("reserved config bits read non-zero");

    a_high_needs_level: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (!aboveHigh && !q.pauseSent)
        |=> !pauseSend)
        else $error("pause frame below high threshold");

    a_below_high_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (!aboveHigh && q.pressureCount == '0)
        |=> !backPressure)
        else $error("back pressure below high threshold");

    a_low_needs_level: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (q.pauseSent && !belowLow)
        |=> !pauseSend)
        else $error("zero pause above low threshold");

    a_no_pause_half: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !fullDuplex
        |=> !pauseSend)
        else $error("pause frame in half duplex");

    a_pause_time_held: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !pauseSend
        |-> $stable(pauseTime))
        else $error("pause time changed without a frame");

    a_flag_on_pause: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (pauseSend && !$past(q.pauseSent))
        |-> q.pauseSent)
        else $error("pause-sent flag not recorded");

    a_pressure_count: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (!fullDuplex && txEnable && !(aboveHigh && frameHit) && q.pressureCount != '0)
        |=> (q.pressureCount == $past(q.pressureCount) - COUNT_W'(1)))
        else $error("pressure period not counting down");

    a_addr_select_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (!anySelect && !rxAddrValid && q.pressureCount == '0)
        |=> !backPressure)
        else $error("back pressure without decoded address");
endmodule : auto_flow_control

// [hdl/flow_ctrl_pkg.sv]
// Constants, register map and timing for the automatic flow control block.
// Assumes a single 200 MHz clock and an APB register port with 32-bit data.
package flow_ctrl_pkg;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned FIFO_W        = 14;
    localparam int unsigned COUNT_W       = 18;
    localparam int unsigned LEVEL_W       = 8;
    localparam int unsigned PERIOD_W      = 4;
    localparam int unsigned SELECT_W      = 4;
    localparam int unsigned PAUSE_W       = 16;
    localparam int unsigned DUR_CODES     = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] WINDOW_DATA_OFS = 12'h0a8;
    localparam logic [ADDR_W-1:0] FLOW_CFG_OFS    = 12'h0ac;

    // Reset values
    localparam logic [DATA_W-1:0]   WINDOW_DATA_RST = 32'h0000_0000;
    localparam logic [LEVEL_W-1:0]  LEVEL_RST       = 8'h00;
    localparam logic [PERIOD_W-1:0] PERIOD_RST      = 4'h0;
    localparam logic [SELECT_W-1:0] SELECT_RST      = 4'h0;
    localparam logic [DATA_W-1:0]   READ_ZERO       = 32'h0000_0000;
    localparam logic [PAUSE_W-1:0]  ZERO_PAUSE      = 16'h0000;

    // Field positions of flow_control_config
    localparam int unsigned HI_LSB    = 16;
    localparam int unsigned LO_LSB    = 8;
    localparam int unsigned DUR_LSB   = 4;
    localparam int unsigned MULT_BIT  = 3;
    localparam int unsigned BRD_BIT   = 2;
    localparam int unsigned OWN_BIT   = 1;
    localparam int unsigned ANY_BIT   = 0;
    localparam int unsigned UNIT_SHIFT = 6;   // Thresholds count 64-byte units

    // Timing
    localparam int unsigned CLK_FREQ_MHZ = 200;
    localparam int unsigned NS_PER_US    = 1000;
    typedef int unsigned dur_table_t [DUR_CODES];
    localparam dur_table_t BP_TIME_100M_NS = '{
        5000, 10000, 15000, 25000, 50000, 100000, 150000, 200000,
        250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};
    localparam int unsigned BP_EXTRA_10M_NS = 2200;

    // Least time rounds up to whole cycles, never below one
    function automatic int unsigned cycles_from_ns(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_FREQ_MHZ + NS_PER_US - 1) / NS_PER_US;
        return (c == 0) ? 1 : c;
    endfunction : cycles_from_ns
endpackage : flow_ctrl_pkg
